/* File: rtl/rsc_pkg.sv */
// Purpose: shared constants and types for the reset source control block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: register offsets are byte addresses
package rsc_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_PIN_SEL = 8'h00;
	localparam logic [7:0] OFS_CAUSE = 8'h04;
	localparam logic [7:0] OFS_LV_SEL = 8'h08;
	localparam logic [7:0] OFS_LV_FILT = 8'h0C;
	localparam logic [7:0] OFS_FLASH_CTL1 = 8'h10;
	localparam logic [7:0] OFS_WDT_CTL = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;

	// reset-pin function patterns
	localparam logic [7:0] PIN_SEL_GPIO = 8'h55;
	localparam logic [7:0] PIN_SEL_RESET = 8'hAA;
	localparam logic [7:0] PIN_SEL_POR = 8'hAA;

	// low-voltage select patterns
	localparam logic [7:0] LV_SEL_ENABLE = 8'h5A;
	localparam logic [7:0] LV_SEL_DISABLE = 8'hA5;
	localparam logic [7:0] LV_SEL_POR = 8'h5A;

	// filter code reset value
	localparam logic [1:0] LV_FILT_POR = 2'h1;

	// watchdog enable patterns (5 bits)
	localparam logic [4:0] WDT_EN_ON = 5'h0A;
	localparam logic [4:0] WDT_EN_OFF = 5'h15;
	localparam logic [4:0] WDT_EN_POR = 5'h0A;

	// flash control key that resets the device
	localparam logic [7:0] FLASH_RESET_KEY = 8'h55;

	// cause flag bit positions
	localparam int CAUSE_WDT_CORRUPT = 0;
	localparam int CAUSE_LV_CORRUPT = 1;
	localparam int CAUSE_LOW_VOLT = 2;
	localparam int CAUSE_SEL_CORRUPT = 3;

	// status register bit positions
	localparam int STAT_TIMEOUT = 0;
	localparam int STAT_POWER_DOWN = 1;

	// filter lengths in slow rc periods (upper figure of each range)
	localparam logic [7:0] LV_FILT_C0 = 8'h08;
	localparam logic [7:0] LV_FILT_C1 = 8'h20;
	localparam logic [7:0] LV_FILT_C2 = 8'h40;
	localparam logic [7:0] LV_FILT_C3 = 8'h80;

	// soft-fault delay default in clock cycles
	localparam int SOFT_FAULT_CYCLES = 64;

	// reset request pulse length in clocks
	localparam logic [3:0] RESET_PULSE = 4'h4;

	// state of the reset sequencer
	typedef enum logic [1:0] {
		RSC_IDLE = 2'b00,
		RSC_FULL = 2'b01,
		RSC_WARM = 2'b10
	} rsc_seq_type;

	// apb request bundle
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} rsc_apb_req_type;

	// whole state of the block
	typedef struct packed {
		logic [7:0] pin_sel;
		logic [3:0] cause;
		logic [7:0] lv_sel;
		logic [1:0] lv_filt;
		logic [4:0] wdt_en;
		logic timeout_status_flag;
		logic power_down_flag;
		logic [15:0] fault_cnt;
		logic [7:0] lv_cnt;
		logic [3:0] pulse_cnt;
		rsc_seq_type seq;
		logic [1:0] rc_sync;
		logic rc_prev;
		logic [1:0] lv_sync;
		logic [1:0] pin_sync;
		logic [1:0] wdt_sync;
		logic wdt_prev;
		logic prdy;
		logic [31:0] prdata;
		logic system_reset;
		logic warm_reset;
		logic shared_pin_output_enable;
		logic pin_is_reset;
	} rsc_state_type;

endpackage

/* File: rtl/rsc_reset_source_control.sv */
// Purpose: reset source selection, cause flags and low-voltage filter
// Assumes: slow rc clock, supply-low, reset pin and watchdog
//          time-out arrive asynchronously; power-on is the reset input
// Notes: one APB slave, all state in one struct
`timescale 1ns/100ps
module rsc_reset_source_control #(
	parameter int SOFT_FAULT_DELAY = rsc_pkg::SOFT_FAULT_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic slow_rc_osc,
	input wire logic supply_low,
	input wire logic ext_rst_n_pin,
	input wire logic watchdog_timeout,
	input wire logic low_power_mode,
	output logic system_reset,
	output logic warm_reset,
	output logic shared_pin_output_enable,
	output logic pin_is_reset
);

	// state and its next value
	rsc_pkg::rsc_state_type r;
	rsc_pkg::rsc_state_type next_r;
	rsc_pkg::rsc_apb_req_type req;

	// filter length for a code, in slow rc periods
	function automatic logic [7:0] filt_len(input logic [1:0] code);
		unique case (code)
			2'b00: filt_len = rsc_pkg::LV_FILT_C0;
			2'b01: filt_len = rsc_pkg::LV_FILT_C1;
			2'b10: filt_len = rsc_pkg::LV_FILT_C2;
			2'b11: filt_len = rsc_pkg::LV_FILT_C3;
		endcase
	endfunction

	// register read mux, used for prdata
	function automatic logic [31:0] rd_mux(input logic [7:0] a,
			input rsc_pkg::rsc_state_type s);
		rd_mux = 32'h0;
		unique case (a)
			rsc_pkg::OFS_PIN_SEL: rd_mux = {24'h0, s.pin_sel};
			rsc_pkg::OFS_CAUSE: rd_mux = {28'h0, s.cause};
			rsc_pkg::OFS_LV_SEL: rd_mux = {24'h0, s.lv_sel};
			rsc_pkg::OFS_LV_FILT: rd_mux = {30'h0, s.lv_filt};
			rsc_pkg::OFS_WDT_CTL: rd_mux = {27'h0, s.wdt_en};
			rsc_pkg::OFS_STATUS: rd_mux = {30'h0, s.power_down_flag,
				s.timeout_status_flag};
			default: rd_mux = 32'h0;
		endcase
	endfunction

	// address belongs to the map
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == rsc_pkg::OFS_PIN_SEL) ||
			(a == rsc_pkg::OFS_CAUSE) || (a == rsc_pkg::OFS_LV_SEL) ||
			(a == rsc_pkg::OFS_LV_FILT) ||
			(a == rsc_pkg::OFS_FLASH_CTL1) ||
			(a == rsc_pkg::OFS_WDT_CTL) || (a == rsc_pkg::OFS_STATUS);
	endfunction

	// bundle the bus inputs
	always_comb begin
		req.psel = psel;
		req.penable = penable;
		req.pwrite = pwrite;
		req.paddr = paddr;
		req.pwdata = pwdata;
	end

	// next-state logic
	always_comb begin
		logic wr;
		logic pin_bad;
		logic lv_bad;
		logic lv_on;
		logic rc_rise;
		logic wdt_rise;
		logic pin_rst;
		logic lv_rst;
		logic key_rst;
		logic fault_fire;
		logic full_req;
		logic [3:0] set_c;
		wr = 1'b0;
		pin_bad = 1'b0;
		lv_bad = 1'b0;
		lv_on = 1'b0;
		rc_rise = 1'b0;
		wdt_rise = 1'b0;
		pin_rst = 1'b0;
		lv_rst = 1'b0;
		key_rst = 1'b0;
		fault_fire = 1'b0;
		full_req = 1'b0;
		set_c = 4'h0;
		next_r = r;

		// two-stage synchronisers; first stage read only by second
		next_r.rc_sync = {r.rc_sync[0], slow_rc_osc};
		next_r.lv_sync = {r.lv_sync[0], supply_low};
		next_r.pin_sync = {r.pin_sync[0], ext_rst_n_pin};
		next_r.wdt_sync = {r.wdt_sync[0], watchdog_timeout};
		next_r.rc_prev = r.rc_sync[1];
		next_r.wdt_prev = r.wdt_sync[1];
		rc_rise = r.rc_sync[1] & ~r.rc_prev;
		wdt_rise = r.wdt_sync[1] & ~r.wdt_prev;

		// apb: one wait state, answer in the second cycle after setup
		next_r.prdy = 1'b0;
		if (req.psel && req.penable && !r.prdy) begin
			next_r.prdy = 1'b1;
			next_r.prdata = rd_mux(req.paddr, r);
		end
		wr = req.psel && req.penable && req.pwrite && r.prdy;

		// software writes; zeros clear cause flags only
		if (wr) begin
			unique case (req.paddr)
				rsc_pkg::OFS_PIN_SEL: next_r.pin_sel = req.pwdata[7:0];
				rsc_pkg::OFS_LV_SEL: next_r.lv_sel = req.pwdata[7:0];
				rsc_pkg::OFS_LV_FILT: next_r.lv_filt = req.pwdata[1:0];
				rsc_pkg::OFS_CAUSE:
					next_r.cause = r.cause & req.pwdata[3:0];
				rsc_pkg::OFS_STATUS: begin
					next_r.timeout_status_flag = req.pwdata[0];
					next_r.power_down_flag = req.pwdata[1];
				end
				rsc_pkg::OFS_WDT_CTL: begin
					next_r.wdt_en = req.pwdata[4:0];
					if (req.pwdata[4:0] != rsc_pkg::WDT_EN_ON &&
							req.pwdata[4:0] != rsc_pkg::WDT_EN_OFF)
						set_c[rsc_pkg::CAUSE_WDT_CORRUPT] = 1'b1;
				end
				rsc_pkg::OFS_FLASH_CTL1:
					key_rst = (req.pwdata[7:0] ==
						rsc_pkg::FLASH_RESET_KEY);
				default: begin
				end
			endcase
		end

		// corrupted selector detection
		pin_bad = (r.pin_sel != rsc_pkg::PIN_SEL_GPIO) &&
			(r.pin_sel != rsc_pkg::PIN_SEL_RESET);
		lv_bad = (r.lv_sel != rsc_pkg::LV_SEL_ENABLE) &&
			(r.lv_sel != rsc_pkg::LV_SEL_DISABLE);
		// detector gated off in sleep and idle
		lv_on = (r.lv_sel == rsc_pkg::LV_SEL_ENABLE) &&
			!low_power_mode;

		// soft-fault delay counter; runs while corruption lasts
		if ((pin_bad || lv_bad) && r.seq == rsc_pkg::RSC_IDLE) begin
			if (r.fault_cnt == 16'(SOFT_FAULT_DELAY - 1))
				fault_fire = 1'b1;
			else
				next_r.fault_cnt = r.fault_cnt + 16'h1;
		end else begin
			next_r.fault_cnt = 16'h0;
		end

		// glitch filter counts slow rc edges while supply low
		if (lv_on && r.lv_sync[1]) begin
			// saturate at the filter length; a long low never wraps
			if (rc_rise && r.lv_cnt < filt_len(r.lv_filt))
				next_r.lv_cnt = r.lv_cnt + 8'h1;
			if (r.lv_cnt >= filt_len(r.lv_filt))
				lv_rst = 1'b1;
		end else begin
			next_r.lv_cnt = 8'h0;
		end

		// pin reset only when selected
		pin_rst = r.pin_is_reset && !r.pin_sync[1];

		if (fault_fire && pin_bad)
			set_c[rsc_pkg::CAUSE_SEL_CORRUPT] = 1'b1;
		if (fault_fire && lv_bad)
			set_c[rsc_pkg::CAUSE_LV_CORRUPT] = 1'b1;
		if (lv_rst)
			set_c[rsc_pkg::CAUSE_LOW_VOLT] = 1'b1;
		// hardware set wins over a software clear
		next_r.cause = next_r.cause | set_c;

		full_req = fault_fire || lv_rst || key_rst || pin_rst ||
			(wdt_rise && !low_power_mode);

		// reset sequencer
		unique case (r.seq)
			rsc_pkg::RSC_IDLE: begin
				if (full_req) begin
					next_r.seq = rsc_pkg::RSC_FULL;
					next_r.pulse_cnt = rsc_pkg::RESET_PULSE;
					next_r.system_reset = 1'b1;
					next_r.pin_sel = rsc_pkg::PIN_SEL_POR;
					next_r.lv_filt = rsc_pkg::LV_FILT_POR;
				end else if (wdt_rise) begin
					// warm timeout: leave pin select and filter untouched, set both status flags
					next_r.seq = rsc_pkg::RSC_WARM;
					next_r.pulse_cnt = rsc_pkg::RESET_PULSE;
					next_r.warm_reset = 1'b1;
					next_r.timeout_status_flag = 1'b1;
					next_r.power_down_flag = 1'b1;
				end
				if (fault_fire && lv_bad)
					next_r.lv_sel = rsc_pkg::LV_SEL_POR;
				if (wdt_rise && !low_power_mode)
					next_r.timeout_status_flag = 1'b1;
			end
			rsc_pkg::RSC_FULL, rsc_pkg::RSC_WARM: begin
				if (r.pulse_cnt == 4'h1) begin
					next_r.seq = rsc_pkg::RSC_IDLE;
					next_r.system_reset = 1'b0;
					next_r.warm_reset = 1'b0;
				end
				next_r.pulse_cnt = r.pulse_cnt - 4'h1;
			end
			default: next_r.seq = rsc_pkg::RSC_IDLE;
		endcase

		// pin function decode; reset selection beats sharing
		next_r.pin_is_reset = (next_r.pin_sel ==
			rsc_pkg::PIN_SEL_RESET);
		next_r.shared_pin_output_enable = (next_r.pin_sel ==
			rsc_pkg::PIN_SEL_GPIO);
	end

	// state register; power-on values on reset
	always_ff @(posedge clock) begin
		if (reset) begin
			r <= '0;
			r.pin_sel <= rsc_pkg::PIN_SEL_POR;
			r.lv_sel <= rsc_pkg::LV_SEL_POR;
			r.lv_filt <= rsc_pkg::LV_FILT_POR;
			r.wdt_en <= rsc_pkg::WDT_EN_POR;
			r.pin_is_reset <= 1'b1;
			r.pin_sync <= 2'b11;
			r.seq <= rsc_pkg::RSC_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from flip-flops, except pslverr tied low
	assign prdata = r.prdata;
	assign pready = r.prdy;
	assign pslverr = 1'b0;
	assign system_reset = r.system_reset;
	assign warm_reset = r.warm_reset;
	assign shared_pin_output_enable = r.shared_pin_output_enable;
	assign pin_is_reset = r.pin_is_reset;

	// corrupt pin selector leads to a full reset in bounded time
	a_pin_fault_reset: assert property (
		@(posedge clock) disable iff (reset)
		(r.fault_cnt == 16'(SOFT_FAULT_DELAY - 1) &&
		r.seq == rsc_pkg::RSC_IDLE &&
		r.pin_sel != rsc_pkg::PIN_SEL_GPIO &&
		r.pin_sel != rsc_pkg::PIN_SEL_RESET) |=>
		(system_reset && r.cause[rsc_pkg::CAUSE_SEL_CORRUPT]))
		else $error("pin select fault gave no reset");
	// pin outputs always match the selector held in the same cycle
	a_pin_oe_decode: assert property (
		@(posedge clock) disable iff (reset)
		(shared_pin_output_enable ==
		(r.pin_sel == rsc_pkg::PIN_SEL_GPIO)) &&
		(pin_is_reset == (r.pin_sel == rsc_pkg::PIN_SEL_RESET)))
		else $error("pin function decode wrong");
	// flags never drop without a software write
	a_flag_sticky: assert property (
		@(posedge clock) disable iff (reset)
		(|($past(r.cause) & ~r.cause)) |->
		$past(psel && pwrite && penable && pready &&
		paddr == rsc_pkg::OFS_CAUSE))
		else $error("cause flag cleared by hardware");
	// unimplemented bits read zero
	a_cause_upper: assert property (
		@(posedge clock) disable iff (reset)
		($past(paddr) == rsc_pkg::OFS_CAUSE && pready) |->
		prdata[31:4] == 28'h0)
		else $error("cause upper bits nonzero");
	// no low-voltage reset without enable
	a_lv_disabled: assert property (
		@(posedge clock) disable iff (reset)
		(low_power_mode || r.lv_sel != rsc_pkg::LV_SEL_ENABLE) |=>
		r.lv_cnt == 8'h0)
		else $error("filter counted while disabled");
	// filter never exceeds its longest length
	a_lv_filter_max: assert property (
		@(posedge clock) disable iff (reset)
		r.lv_cnt <= rsc_pkg::LV_FILT_C3)
		else $error("filter count overran");
	// warm reset sets both timeout and power-down
	a_warm_flags: assert property (
		@(posedge clock) disable iff (reset)
		$rose(warm_reset) |-> (r.timeout_status_flag &&
		r.power_down_flag && !system_reset))
		else $error("warm reset flags wrong");
	// a full reset ends within a few cycles
	a_reset_pulse: assert property (
		@(posedge clock) disable iff (reset)
		$rose(system_reset) |-> ##[1:4] !system_reset)
		else $error("reset pulse too long");
	// a corrupt low-voltage select comes back at its power-on value
	a_lv_sel_restore: assert property (
		@(posedge clock) disable iff (reset)
		(r.fault_cnt == 16'(SOFT_FAULT_DELAY - 1) &&
		r.seq == rsc_pkg::RSC_IDLE &&
		r.lv_sel != rsc_pkg::LV_SEL_ENABLE &&
		r.lv_sel != rsc_pkg::LV_SEL_DISABLE) |=>
		(r.lv_sel == rsc_pkg::LV_SEL_POR &&
		r.cause[rsc_pkg::CAUSE_LV_CORRUPT]))
		else $error("bad low-voltage select not restored");
	// the flash key write starts a full reset at once
	a_key_reset: assert property (
		@(posedge clock) disable iff (reset)
		(psel && penable && pwrite && pready &&
		paddr == rsc_pkg::OFS_FLASH_CTL1 &&
		pwdata[7:0] == rsc_pkg::FLASH_RESET_KEY &&
		r.seq == rsc_pkg::RSC_IDLE) |=> system_reset)
		else $error("flash key gave no reset");
	// a low level on the selected reset pin starts a full reset
	a_pin_low_reset: assert property (
		@(posedge clock) disable iff (reset)
		(pin_is_reset && !r.pin_sync[1] &&
		r.seq == rsc_pkg::RSC_IDLE) |=> system_reset)
		else $error("reset pin low gave no reset");
	// an invalid watchdog enable pattern raises its flag
	a_wdt_flag: assert property (
		@(posedge clock) disable iff (reset)
		(psel && penable && pwrite && pready &&
		paddr == rsc_pkg::OFS_WDT_CTL &&
		pwdata[4:0] != rsc_pkg::WDT_EN_ON &&
		pwdata[4:0] != rsc_pkg::WDT_EN_OFF) |=>
		r.cause[rsc_pkg::CAUSE_WDT_CORRUPT])
		else $error("bad watchdog pattern not flagged");
	// reads of unmapped offsets return zero, never stale data
	a_hole_reads_zero: assert property (
		@(posedge clock) disable iff (reset)
		(pready && !is_mapped(paddr)) |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	// unimplemented filter bits read zero
	a_filt_upper: assert property (
		@(posedge clock) disable iff (reset)
		(pready && paddr == rsc_pkg::OFS_LV_FILT) |->
		prdata[31:2] == 30'h0)
		else $error("filter upper bits nonzero");

endmodule

/* File: dv/rsc_reset_source_control_tb.sv */
// Purpose: self-checking bench for the reset source control block
// Assumes: apb answers with one wait state, soft-fault delay set to 4
// Notes: slow rc clock is derived here, eight system clocks a period
`timescale 1ns/100ps
module rsc_reset_source_control_tb;
	logic clock; // 200 MHz system clock
	logic reset; // power-on reset, synchronous
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic slow_rc_osc; // slow rc clock made from a divider
	logic supply_low; // high while the supply is below threshold
	logic ext_rst_n_pin; // shared pin, low asks for a reset
	logic watchdog_timeout; // rising edge is a time-out
	logic low_power_mode; // high in sleep or idle
	logic system_reset;
	logic warm_reset;
	logic shared_pin_output_enable;
	logic pin_is_reset;
	logic [2:0] rc_cnt; // divider for the slow rc clock
	logic [31:0] rd; // last read word
	int miscompares;
	int cmp_count;
	wire logic [1:0] rst_o = {warm_reset, system_reset}; // 0 full, 1 warm

	rsc_reset_source_control #(.SOFT_FAULT_DELAY(4))
			rsc_reset_source_control_inst (
		.clock(clock), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .slow_rc_osc(slow_rc_osc),
		.supply_low(supply_low), .ext_rst_n_pin(ext_rst_n_pin),
		.watchdog_timeout(watchdog_timeout), .low_power_mode(low_power_mode),
		.system_reset(system_reset), .warm_reset(warm_reset),
		.shared_pin_output_enable(shared_pin_output_enable),
		.pin_is_reset(pin_is_reset));

	// clock source
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// slow rc clock runs free, driven on the rising edge
	always @(posedge clock) begin
		rc_cnt <= rc_cnt + 3'h1;
		slow_rc_osc <= rc_cnt[2];
	end

	// prints the counts and the verdict, then ends the run
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// one compare for every word-sized result
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one apb transfer; entered just after a rising edge, left one idle
	// edge after the answer so that back-to-back calls never overlap
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		logic ok;
		n = 0;
		ok = 1'b0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// request holds until the rising edge that samples pready high
		do begin
			@(posedge clock);
			n++;
			ok = (pready === 1'b1);
		end while (!ok && n < 40);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
		if (!ok) begin
			miscompares++;
			report_and_stop();
		end
	endtask

	// read a register and compare the whole word
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// compare the two pin-sharing outputs: {enable, reset input}
	task automatic pinchk(input logic oe, input logic isr);
		chk({30'h0, shared_pin_output_enable, pin_is_reset}, {30'h0, oe, isr});
	endtask

	// wait, bounded, for a reset pulse of kind sel and for its end
	task automatic wait_rst(input int sel, input int max);
		int n;
		n = 0;
		while (rst_o[sel] !== 1'b1 && n < max) begin
			@(negedge clock);
			n++;
		end
		chk({31'h0, rst_o[sel]}, 32'h1);
		if (rst_o[sel] !== 1'b1) begin
			report_and_stop();
		end
		while (rst_o[sel] !== 1'b0 && n < max + 20) begin
			@(negedge clock);
			n++;
		end
		if (n >= max + 20) begin
			miscompares++;
			report_and_stop();
		end
		@(posedge clock);
	endtask

	// no reset of any kind may show for cyc cycles
	task automatic quiet(input int cyc);
		logic seen;
		seen = 1'b0;
		repeat (cyc) begin
			@(negedge clock);
			seen = seen | (|rst_o);
		end
		chk({31'h0, seen}, 32'h0);
		@(posedge clock);
	endtask

	// power-on values and unimplemented bits
	task automatic t_por();
		rdchk(rsc_pkg::OFS_PIN_SEL, 32'h000000AA);
		rdchk(rsc_pkg::OFS_LV_SEL, 32'h0000005A);
		rdchk(rsc_pkg::OFS_LV_FILT, 32'h00000001);
		pinchk(1'b0, 1'b1);
		apb(1'b1, rsc_pkg::OFS_LV_FILT, 32'hFFFFFFFF);
		rdchk(rsc_pkg::OFS_LV_FILT, 32'h00000003);
		apb(1'b1, rsc_pkg::OFS_CAUSE, 32'hFFFFFF00);
		rdchk(rsc_pkg::OFS_CAUSE, 32'h00000000);
		rdchk(8'h1C, 32'h00000000);
		$display("test por done");
	endtask

	// gpio use ignores the pin; reset use obeys it; flash key resets
	task automatic t_pin();
		apb(1'b1, rsc_pkg::OFS_PIN_SEL, 32'h00000055);
		pinchk(1'b1, 1'b0);
		ext_rst_n_pin <= 1'b0;
		quiet(20);
		ext_rst_n_pin <= 1'b1;
		apb(1'b1, rsc_pkg::OFS_FLASH_CTL1, 32'h00000055);
		wait_rst(0, 30);
		rdchk(rsc_pkg::OFS_PIN_SEL, 32'h000000AA);
		pinchk(1'b0, 1'b1);
		ext_rst_n_pin <= 1'b0;
		wait_rst(0, 30);
		ext_rst_n_pin <= 1'b1;
		repeat (4) @(posedge clock);
		$display("test pin done");
	endtask

	// corrupted select registers reset after the delay and flag it
	task automatic t_corrupt();
		apb(1'b1, rsc_pkg::OFS_PIN_SEL, 32'h00000033);
		wait_rst(0, 40);
		rdchk(rsc_pkg::OFS_CAUSE, 32'h00000008);
		rdchk(rsc_pkg::OFS_PIN_SEL, 32'h000000AA);
		apb(1'b1, rsc_pkg::OFS_CAUSE, 32'h00000000);
		rdchk(rsc_pkg::OFS_CAUSE, 32'h00000000);
		apb(1'b1, rsc_pkg::OFS_LV_SEL, 32'h00000012);
		wait_rst(0, 40);
		rdchk(rsc_pkg::OFS_CAUSE, 32'h00000002);
		rdchk(rsc_pkg::OFS_LV_SEL, 32'h0000005A);
		apb(1'b1, rsc_pkg::OFS_WDT_CTL, 32'h00000003);
		rdchk(rsc_pkg::OFS_WDT_CTL, 32'h00000003);
		rdchk(rsc_pkg::OFS_CAUSE, 32'h00000003);
		apb(1'b1, rsc_pkg::OFS_CAUSE, 32'h00000000);
		apb(1'b1, rsc_pkg::OFS_WDT_CTL, 32'h0000000A);
		rdchk(rsc_pkg::OFS_CAUSE, 32'h00000000);
		$display("test corrupt done");
	endtask

	// low supply filter, disable pattern and low-power masking
	task automatic t_lv();
		apb(1'b1, rsc_pkg::OFS_LV_FILT, 32'h00000000);
		supply_low <= 1'b1;
		quiet(24);
		supply_low <= 1'b0;
		low_power_mode <= 1'b1;
		@(posedge clock);
		supply_low <= 1'b1;
		quiet(120);
		supply_low <= 1'b0;
		low_power_mode <= 1'b0;
		apb(1'b1, rsc_pkg::OFS_LV_SEL, 32'h000000A5);
		supply_low <= 1'b1;
		quiet(120);
		supply_low <= 1'b0;
		apb(1'b1, rsc_pkg::OFS_LV_SEL, 32'h0000005A);
		supply_low <= 1'b1;
		wait_rst(0, 200);
		supply_low <= 1'b0;
		rdchk(rsc_pkg::OFS_CAUSE, 32'h00000004);
		rdchk(rsc_pkg::OFS_LV_SEL, 32'h0000005A);
		apb(1'b1, rsc_pkg::OFS_CAUSE, 32'h00000000);
		$display("test lv done");
	endtask

	// one rising edge on the time-out input
	task automatic wdt_pulse();
		watchdog_timeout <= 1'b1;
		repeat (4) @(posedge clock);
		watchdog_timeout <= 1'b0;
	endtask

	// watchdog time-out in normal and in low-power mode
	task automatic t_wdt();
		wdt_pulse();
		wait_rst(0, 30);
		rdchk(rsc_pkg::OFS_STATUS, 32'h00000001);
		apb(1'b1, rsc_pkg::OFS_PIN_SEL, 32'h00000055);
		low_power_mode <= 1'b1;
		wdt_pulse();
		wait_rst(1, 30);
		rdchk(rsc_pkg::OFS_STATUS, 32'h00000003);
		rdchk(rsc_pkg::OFS_PIN_SEL, 32'h00000055);
		pinchk(1'b1, 1'b0);
		low_power_mode <= 1'b0;
		$display("test wdt done");
	endtask

	// main sequence
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rc_cnt = 3'h0;
		slow_rc_osc = 1'b0;
		supply_low = 1'b0;
		ext_rst_n_pin = 1'b1;
		watchdog_timeout = 1'b0;
		low_power_mode = 1'b0;
		miscompares = 0;
		cmp_count = 0;
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		t_por();
		t_pin();
		t_corrupt();
		t_lv();
		t_wdt();
		report_and_stop();
	end
endmodule
